// ---- pkg/mcdf_pkg.sv ----
package mcdf_pkg;

  // Request codes: prefix byte then selector byte
  localparam logic [7:0] MCDF_CMD_PREFIX = 8'hA5;
  localparam logic [7:0] MCDF_CMD_CFG    = 8'hC1;
  localparam logic [7:0] MCDF_CMD_DAT    = 8'hD1;

  // Block lengths, counting every byte including code and checksum
  localparam logic [7:0] MCDF_CFG_LEN    = 8'h84;
  localparam logic [7:0] MCDF_DAT_LEN    = 8'hC2;

  // Configuration header, bytes 0 to 15
  localparam logic [15:0][7:0] MCDF_CFG_HDR = {
    8'hA5, 8'hC1, 8'h84, 8'h01, 8'h00, 8'h00, 8'h0A, 8'h02,
    8'h64, 8'h01, 8'h00, 8'h04, 8'h00, 8'h54, 8'h00, 8'h5C
  };
  localparam logic [7:0] MCDF_HDR_END    = 8'h10;

  // Channel descriptors
  localparam int         MCDF_NUM_CH     = 10;
  localparam logic [7:0] MCDF_DESC_LEN   = 8'h0A;
  localparam logic [7:0] MCDF_DESC_END   = 8'h74;
  localparam logic [7:0] MCDF_CH_TYPE    = 8'h01;
  localparam logic [7:0] MCDF_SF_TYPE    = 8'hFF;
  localparam logic [7:0] MCDF_SF_OFS     = 8'h00;
  localparam logic [3:0] MCDF_VOLT_FIRST = 4'h4;
  localparam logic [3:0] MCDF_VOLT_LAST  = 4'h6;

  // Names in wye order; entry 0 is sent first
  localparam logic [0:9][47:0] MCDF_NAME_WYE = {
    48'h494100000000, 48'h494200000000, 48'h494300000000,
    48'h494E00000000, 48'h564100000000, 48'h564200000000,
    48'h564300000000, 48'h565300000000, 48'h465245510000,
    48'h564241540000
  };
  // Line-to-line names for entries 4 to 6 under delta
  localparam logic [0:2][47:0] MCDF_NAME_DELTA = {
    48'h564142000000, 48'h564243000000, 48'h564341000000
  };

  // Tail after descriptors, bytes 116 to 130
  localparam logic [7:0] MCDF_LINE_ABC_WYE   = 8'h00;
  localparam logic [7:0] MCDF_LINE_ACB_WYE   = 8'h01;
  localparam logic [7:0] MCDF_LINE_ABC_DELTA = 8'h02;
  localparam logic [7:0] MCDF_LINE_ACB_DELTA = 8'h03;
  localparam logic [7:0] MCDF_PWR_WYE        = 8'h00;
  localparam logic [7:0] MCDF_PWR_DELTA      = 8'h01;
  localparam logic [7:0] MCDF_ABSENT         = 8'hFF;
  localparam logic [7:0] MCDF_RESERVED       = 8'h00;
  localparam logic [5:0][7:0] MCDF_CH_INDEX = {
    8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06
  };
  localparam logic [7:0] MCDF_IDX_LINE       = 8'h74;
  localparam logic [7:0] MCDF_IDX_PWR        = 8'h75;
  localparam logic [7:0] MCDF_IDX_COMP_END   = 8'h7C;
  localparam logic [7:0] MCDF_IDX_CHIDX_END  = 8'h82;
  localparam logic [7:0] MCDF_CFG_RSV        = 8'h82;

  // Data block positions
  localparam logic [7:0] MCDF_DAT_SRC_FIRST  = 8'h03;
  localparam logic [7:0] MCDF_DAT_SRC_LAST   = 8'hBF;
  localparam logic [7:0] MCDF_DAT_RSV        = 8'hC0;

  typedef enum logic [1:0] {MCDF_IDLE, MCDF_SEND} mcdf_state_t;

endpackage

// ---- logic/mcdf_csum.sv ----
`timescale 1ns/10ps
module mcdf_csum (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] sum
);
  import mcdf_pkg::*;

  logic [7:0] sum_r;

  // Eight-bit wrap is the truncation the host expects
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sum_r <= 8'h00;
    end else if (clr) begin
      sum_r <= 8'h00;
    end else if (add) begin
      sum_r <= sum_r + byte_in;
    end
  end

  assign sum = sum_r;

endmodule

// ---- logic/mcdf_framer.sv ----
`timescale 1ns/10ps
// Overview of operation
// - A two-byte configuration request starts a block that opens with that code and length 84.
// - The header reports ten channels, two samples, 100 banks, offsets 0054 and 005C.
// - The header declares one status byte, scale factors in message, none of them, one calc block.
// - Each descriptor is a six-byte zero-padded name, type 01, scale type FF, offset 0000.
// - Descriptors go currents, neutral, three voltages, sync, frequency, then battery.
// - Voltage descriptors carry phase names under wye and line names under delta, never both.
// - Line configuration byte is 00, 01, 02 or 03 by rotation and connection.
// - Power calculation byte is 00 under wye and 01 under delta.
// - Deskew, resistance and reactance compensation are each sent as FFFF.
// - Channel indices 00 01 02 04 05 06 follow the compensation fields.
// - The configuration block ends with reserved 00 and a checksum of all prior bytes.
// - A two-byte data request starts a block with that code, length C2 and a status byte.
// - Eighty bytes of X and Y float components follow the status byte.
// - An 8-byte time stamp, 100 target and bank bytes, a reserved byte and checksum follow.
module mcdf_framer (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       pt_connection_setting,
  input  wire logic       phase_rotation_acb,
  input  wire logic [7:0] data_src_byte,
  output logic      [7:0] data_src_index,
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic            busy
);
  import mcdf_pkg::*;

  mcdf_state_t state_r;
  logic        prefix_seen_r;
  logic        kind_dat_r;
  logic        delta_r;
  logic        acb_r;
  logic [7:0]  idx_r;
  logic [7:0]  tx_data_r;
  logic        tx_valid_r;
  logic        start_cfg;
  logic        start_dat;
  logic        load;
  logic        last;
  logic [7:0]  cur_byte;
  logic [7:0]  cfg_byte;
  logic [7:0]  dat_byte;
  logic [7:0]  csum;
  logic [7:0]  rel;
  logic [3:0]  ch;
  logic [3:0]  pos;
  logic [47:0] name;

  // Requests are only decoded while idle; a request arriving mid-block
  // is dropped rather than queued, so the host must wait for the checksum
  assign start_cfg = (state_r == MCDF_IDLE) && rx_valid && prefix_seen_r
                     && (rx_data == MCDF_CMD_CFG);
  assign start_dat = (state_r == MCDF_IDLE) && rx_valid && prefix_seen_r
                     && (rx_data == MCDF_CMD_DAT);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prefix_seen_r <= 1'b0;
    end else if (state_r != MCDF_IDLE) begin
      prefix_seen_r <= 1'b0;
    end else if (rx_valid) begin
      prefix_seen_r <= (rx_data == MCDF_CMD_PREFIX);
    end
  end

  assign load = (state_r == MCDF_SEND) && (!tx_valid_r || tx_ready);
  assign last = kind_dat_r ? (idx_r == MCDF_DAT_LEN - 8'h01)
                           : (idx_r == MCDF_CFG_LEN - 8'h01);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= MCDF_IDLE;
    end else begin
      unique case (state_r)
        MCDF_IDLE: begin
          if (start_cfg || start_dat) begin
            state_r <= MCDF_SEND;
          end
        end
        MCDF_SEND: begin
          if (load && last) begin
            state_r <= MCDF_IDLE;
          end
        end
        default: state_r <= MCDF_IDLE;
      endcase
    end
  end

  // Settings are frozen per block so one block never mixes name sets
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kind_dat_r <= 1'b0;
      delta_r    <= 1'b0;
      acb_r      <= 1'b0;
    end else if (start_cfg || start_dat) begin
      kind_dat_r <= start_dat;
      delta_r    <= pt_connection_setting;
      acb_r      <= phase_rotation_acb;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_r <= 8'h00;
    end else if (start_cfg || start_dat) begin
      idx_r <= 8'h00;
    end else if (load) begin
      idx_r <= idx_r + 8'h01;
    end
  end

  // Descriptor decode
  always_comb begin
    rel  = idx_r - MCDF_HDR_END;
    ch   = 4'(rel / MCDF_DESC_LEN);
    pos  = 4'(rel % MCDF_DESC_LEN);
    name = MCDF_NAME_WYE[ch];
    if (delta_r && ch >= MCDF_VOLT_FIRST && ch <= MCDF_VOLT_LAST) begin
      name = MCDF_NAME_DELTA[2'(ch - MCDF_VOLT_FIRST)];
    end
  end

  always_comb begin
    cfg_byte = MCDF_RESERVED;
    if (idx_r < MCDF_HDR_END) begin
      cfg_byte = MCDF_CFG_HDR[4'(MCDF_HDR_END - 8'h01 - idx_r)];
    end else if (idx_r < MCDF_DESC_END) begin
      if (pos < 4'h6) begin
        cfg_byte = name[8'(47 - 8 * pos) -: 8];
      end else if (pos == 4'h6) begin
        cfg_byte = MCDF_CH_TYPE;
      end else if (pos == 4'h7) begin
        cfg_byte = MCDF_SF_TYPE;
      end else begin
        cfg_byte = MCDF_SF_OFS;
      end
    end else if (idx_r == MCDF_IDX_LINE) begin
      unique case ({delta_r, acb_r})
        2'b00: cfg_byte = MCDF_LINE_ABC_WYE;
        2'b01: cfg_byte = MCDF_LINE_ACB_WYE;
        2'b10: cfg_byte = MCDF_LINE_ABC_DELTA;
        2'b11: cfg_byte = MCDF_LINE_ACB_DELTA;
      endcase
    end else if (idx_r == MCDF_IDX_PWR) begin
      cfg_byte = delta_r ? MCDF_PWR_DELTA : MCDF_PWR_WYE;
    end else if (idx_r < MCDF_IDX_COMP_END) begin
      cfg_byte = MCDF_ABSENT;
    end else if (idx_r < MCDF_IDX_CHIDX_END) begin
      cfg_byte = MCDF_CH_INDEX[3'(MCDF_IDX_CHIDX_END - 8'h01 - idx_r)];
    end else if (idx_r == MCDF_CFG_RSV) begin
      cfg_byte = MCDF_RESERVED;
    end
  end

  // Status, phasors, time stamp and banks all come from the source port
  always_comb begin
    dat_byte = MCDF_RESERVED;
    if (idx_r == 8'h00) begin
      dat_byte = MCDF_CMD_PREFIX;
    end else if (idx_r == 8'h01) begin
      dat_byte = MCDF_CMD_DAT;
    end else if (idx_r == 8'h02) begin
      dat_byte = MCDF_DAT_LEN;
    end else if (idx_r <= MCDF_DAT_SRC_LAST) begin
      dat_byte = data_src_byte;
    end else if (idx_r == MCDF_DAT_RSV) begin
      dat_byte = MCDF_RESERVED;
    end
  end

  always_comb begin
    if (last) begin
      cur_byte = csum;
    end else if (kind_dat_r) begin
      cur_byte = dat_byte;
    end else begin
      cur_byte = cfg_byte;
    end
  end

  mcdf_csum u_csum (
    .mclk    (mclk),
    .rstn    (rstn),
    .clr     (start_cfg || start_dat),
    .add     (load && !last),
    .byte_in (cur_byte),
    .sum     (csum)
  );

  // One-byte output stage; the next byte loads on the same edge that
  // the host takes the current one, so a ready host sees no gaps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_data_r  <= 8'h00;
      tx_valid_r <= 1'b0;
    end else if (load) begin
      tx_data_r  <= cur_byte;
      tx_valid_r <= 1'b1;
    end else if (tx_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  assign tx_data        = tx_data_r;
  assign tx_valid       = tx_valid_r;
  assign data_src_index = idx_r;
  assign busy           = (state_r == MCDF_SEND) || tx_valid_r;

endmodule

// ---- tb/mcdf_framer_properties.sv ----
`timescale 1ns/10ps
module mcdf_framer_props (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       pt_connection_setting,
  input wire logic       phase_rotation_acb,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       busy
);
  logic [7:0] cnt_r;
  logic [7:0] sum_r;
  logic       pfx_r;
  logic       cfg_r;
  wire        take = tx_valid && tx_ready;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Byte count and running sum restart whenever no block is open
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
    end else if (!busy) begin
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
    end else if (take) begin
      cnt_r <= cnt_r + 8'h01;
      sum_r <= sum_r + tx_data;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pfx_r <= 1'b0;
      cfg_r <= 1'b0;
    end else begin
      if (rx_valid) pfx_r <= (rx_data == 8'hA5) && !busy;
      if (take && cnt_r == 8'h01) cfg_r <= (tx_data == 8'hC1);
    end
  end
  sequence first_out;
    busy ##1 (tx_valid && tx_data == 8'hA5);
  endsequence
  start_cfg_a: assert property (!busy && rx_valid && rx_data == 8'hC1 && pfx_r
    |=> first_out) else $error("config block did not open");
  start_dat_a: assert property (!busy && rx_valid && rx_data == 8'hD1 && pfx_r
    |=> first_out) else $error("data block did not open");
  tx_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data)) else $error("byte dropped");
  len_byte_a: assert property (tx_valid && cnt_r == 8'h02
    |-> tx_data == (cfg_r ? 8'h84 : 8'hC2)) else $error("bad length");
  block_len_a: assert property (take |=> busy || $past(cnt_r) inside
    {8'h83, 8'hC1}) else $error("bad block size");
  csum_last_a: assert property (take |=> busy ||
    $past(tx_data) == $past(sum_r)) else $error("bad checksum");
  line_cfg_a: assert property (tx_valid && cfg_r && cnt_r == 8'h74 |->
    tx_data == {6'h00, pt_connection_setting, phase_rotation_acb})
    else $error("bad line code");
  pwr_calc_a: assert property (tx_valid && cfg_r && cnt_r == 8'h75 |->
    tx_data == {7'h00, pt_connection_setting})
    else $error("bad power code");
endmodule
bind mcdf_framer mcdf_framer_props u_props (.mclk(mclk), .rstn(rstn),
  .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
  .pt_connection_setting(pt_connection_setting), .tx_valid(tx_valid),
  .phase_rotation_acb(phase_rotation_acb), .tx_ready(tx_ready),
  .busy(busy));

// ---- tb/mcdf_host_model.sv ----
`timescale 1ns/10ps
module mcdf_host_model (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic [7:0] data_src_index,
  output logic      [7:0] data_src_byte,
  output logic            tx_ready
);
  logic [1:0] ph_r = 2'h0;
  // Store answers the inverse of its index, so a stale index shows up
  assign data_src_byte = ~data_src_index;
  initial tx_ready = 1'b1;
  // A slow host takes one byte in four
  always @(negedge mclk) begin
    ph_r <= ph_r + 2'h1;
    tx_ready <= !slow || ph_r == 2'h3;
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import mcdf_pkg::*;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic       rx_valid = 1'b0;
  logic       pt_connection_setting = 1'b0;
  logic       phase_rotation_acb = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] data_src_byte, data_src_index, tx_data;
  logic       tx_valid, tx_ready, busy;
  logic [7:0] got [0:193];
  int         n, errors = 0, tests_run = 0, cycles = 0;
  localparam logic [7:0] HDR [0:15] = '{8'hA5, 8'hC1, 8'h84, 8'h01, 8'h00,
    8'h00, 8'h0A, 8'h02, 8'h64, 8'h01, 8'h00, 8'h04, 8'h00, 8'h54, 8'h00,
    8'h5C};
  mcdf_framer dut (.mclk(mclk), .rstn(rstn), .rx_data(rx_data),
    .rx_valid(rx_valid), .pt_connection_setting(pt_connection_setting),
    .phase_rotation_acb(phase_rotation_acb), .data_src_byte(data_src_byte),
    .data_src_index(data_src_index), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));
  mcdf_host_model host (.mclk(mclk), .slow(slow),
    .data_src_index(data_src_index), .data_src_byte(data_src_byte),
    .tx_ready(tx_ready));
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  task close_out;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp8(input logic [7:0] g, input logic [7:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task send(input logic [7:0] b);
    @(negedge mclk);
    rx_data = b;
    rx_valid = 1'b1;
    @(negedge mclk);
    rx_valid = 1'b0;
  endtask
  // Read before the edge's updates land, so the taken byte is seen
  task collect(input int len);
    n = 0;
    while (n < len) begin
      @(posedge mclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        got[n] = tx_data;
        n++;
      end
    end
    @(negedge mclk);
  endtask
  function automatic logic [7:0] exp_cfg(input int i, input logic d, a);
    logic [47:0] nm;
    int ch, k;
    ch = (i - 16) / 10;
    k = (i - 16) % 10;
    if (i < 16) return HDR[i];
    if (i < 116) begin
      nm = (d && ch > 3 && ch < 7) ? MCDF_NAME_DELTA[ch-4] : MCDF_NAME_WYE[ch];
      if (k < 6) return nm[47-8*k -: 8];
      return k == 6 ? 8'h01 : k == 7 ? 8'hFF : 8'h00;
    end
    if (i == 116) return {6'h00, d, a};
    if (i == 117) return {7'h00, d};
    if (i < 124) return 8'hFF;
    if (i < 130) return 8'(i < 127 ? i - 124 : i - 123);
    return 8'h00;
  endfunction
  // Store bytes come back as the inverse of their position
  function automatic logic [7:0] exp_dat(input int i);
    if (i == 0) return 8'hA5;
    if (i == 1) return 8'hD1;
    if (i == 2) return 8'hC2;
    if (i == 192) return 8'h00;
    return ~8'(i);
  endfunction
  task check_block(input int len, input logic cfg);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < len - 1; i++) begin
      s += got[i];
      if (cfg) cmp8(got[i], exp_cfg(i, pt_connection_setting,
        phase_rotation_acb), "cfg byte");
      else cmp8(got[i], exp_dat(i), "data byte");
    end
    cmp8(got[len-1], s, "checksum");
    cmp8({7'h00, busy}, 8'h00, "busy after block");
  endtask
  task test_cfg;
    for (int m = 0; m < 4; m++) begin
      pt_connection_setting = m[1];
      phase_rotation_acb = m[0];
      send(8'hA5);
      send(8'hC1);
      collect(132);
      check_block(132, 1'b1);
    end
    $display("test cfg done");
  endtask
  // Host stalls most cycles; a request sent mid-block must be dropped
  task test_data;
    slow = 1'b1;
    send(8'hA5);
    send(8'hD1);
    fork
      collect(194);
      begin
        repeat (8) @(negedge mclk);
        send(8'hA5);
        send(8'hC1);
      end
    join
    check_block(194, 1'b0);
    slow = 1'b0;
    $display("test data done");
  endtask
  // Reset in mid-block must have closed the open block by the next falling edge
  task test_reset;
    send(8'hA5);
    send(8'hC1);
    repeat (10) @(negedge mclk);
    rstn = 1'b0;
    @(negedge mclk);
    cmp8({6'h00, busy, tx_valid}, 8'h00, "reset mid-block");
    rstn = 1'b1;
    $display("test reset done");
  endtask
  task test_cancel;
    send(8'hA5);
    send(8'h00);
    send(8'hC1);
    repeat (4) @(negedge mclk);
    cmp8({7'h00, busy}, 8'h00, "broken prefix");
    $display("test cancel done");
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    test_cfg();
    test_data();
    test_reset();
    test_cancel();
    close_out();
  end
endmodule
